// file: hw/sorm_pkg.sv
// Constants, register map and mode types for the servo output route and
// mode select block. Assumes one 10 MHz clock and a classic Wishbone host.
//
// Summary of operation
// - Routing nibble 0 disables a function, 1 to 3 pick terminals 1 to 3.
// - Word one nibbles route positioning, speed coincidence, rotation, ready.
// - Word one resets to 3211.
// - Word two nibbles route torque limit, speed limit, brake, warning.
// - Word two resets to 0000, leaving those four functions disabled.
// - Word three low nibble routes near-position; word resets to 0000.
// - Functions sharing a terminal are combined by OR.
// - A function not detected in the current mode contributes inactive.
// - Per-terminal polarity word, reset 0000.
// - Polarity digits 0..2 invert terminals 1..3 when 1; digit 3 unused.
// - Mode digit picks control mode, reset 0 meaning analog speed.
// - Mode 0 speed, 1 position, 2 torque, 3 contact; 4..9 switched pairs, A zero clamp, B inhibit.
// - Contact mode picks one of three preset speeds from two contacts, A and B.
// - Modes 4,5,6 leave contact mode when select A and B are both off.
// - Mode 7 switches position and analog speed by mode-select input.
// - Mode 8 switches position and analog torque by mode-select input.
// - Zero-clamp mode clamps while the zero-clamp input is on.
// - Inhibit mode blocks reference pulses while inhibit input is on.
package sorm_pkg;

    // ---------------------------------------------------------------
    // Register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_ROUTE_ONE = 8'h00;
    localparam logic [7:0] ADDR_ROUTE_TWO = 8'h04;
    localparam logic [7:0] ADDR_ROUTE_THREE = 8'h08;
    localparam logic [7:0] ADDR_POLARITY = 8'h0C;
    localparam logic [7:0] ADDR_MODE = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] RST_ROUTE_ONE = 16'h3211;
    localparam logic [15:0] RST_ROUTE_TWO = 16'h0000;
    localparam logic [15:0] RST_ROUTE_THREE = 16'h0000;
    localparam logic [15:0] RST_POLARITY = 16'h0000;
    localparam logic [3:0] RST_MODE = 4'h0;

    // ---------------------------------------------------------------
    // Field layout
    // ---------------------------------------------------------------
    localparam int NIBBLE_W = 4;
    localparam int NUM_FUNC = 9;
    localparam int NUM_TERM = 3;
    localparam logic [3:0] ROUTE_OFF = 4'h0;
    localparam logic [3:0] POL_INVERT = 4'h1;
    // Status word bit positions
    localparam int ST_TERM_LSB = 0;
    localparam int ST_MODE_LSB = 4;
    localparam int ST_SPEED_LSB = 8;
    localparam int ST_REVERSE = 10;
    localparam int ST_CLAMP = 11;
    localparam int ST_INHIBIT = 12;

    // ---------------------------------------------------------------
    // Mode digit codes
    // ---------------------------------------------------------------
    localparam logic [3:0] MD_SPEED = 4'h0;
    localparam logic [3:0] MD_POS = 4'h1;
    localparam logic [3:0] MD_TORQUE = 4'h2;
    localparam logic [3:0] MD_CONTACT = 4'h3;
    localparam logic [3:0] MD_CONT_SPEED = 4'h4;
    localparam logic [3:0] MD_CONT_POS = 4'h5;
    localparam logic [3:0] MD_CONT_TORQUE = 4'h6;
    localparam logic [3:0] MD_POS_SPEED = 4'h7;
    localparam logic [3:0] MD_POS_TORQUE = 4'h8;
    localparam logic [3:0] MD_TORQUE_SPEED = 4'h9;
    localparam logic [3:0] MD_CLAMP = 4'hA;
    localparam logic [3:0] MD_INHIBIT = 4'hB;

    // Active control loop
    typedef enum logic [1:0] {
        LOOP_SPEED,
        LOOP_POSITION,
        LOOP_TORQUE,
        LOOP_CONTACT
    } sorm_loop_t;

endpackage : sorm_pkg

// file: hw/sorm_top.sv
// Output terminal routing and control mode decode for a servo amplifier.
// Assumes internal status functions on clk_i and contact inputs from pins.
`timescale 1ns/1ps
`default_nettype none

module sorm_top
    import sorm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Internal status functions, active high, same clock
    input wire logic positioning_completed_i,
    input wire logic speed_coincidence_i,
    input wire logic rotation_detected_i,
    input wire logic servo_ready_i,
    input wire logic torque_limit_detected_i,
    input wire logic speed_limit_detected_i,
    input wire logic brake_interlock_i,
    input wire logic warning_i,
    input wire logic near_position_i,
    // Contact inputs from pins, on = low
    input wire logic proportional_control_input_n_i,
    input wire logic speed_select_direction_n_i,
    input wire logic speed_select_a_n_i,
    input wire logic speed_select_b_n_i,
    // Sequence output terminals, high = active unless the terminal's polarity digit is 1
    output logic output_terminal_one_o,
    output logic output_terminal_two_o,
    output logic output_terminal_three_o,
    // Decoded mode
    output sorm_pkg::sorm_loop_t active_loop_o,
    output logic [1:0] preset_speed_o,
    output logic speed_reverse_o,
    output logic zero_clamp_o,
    output logic pulse_inhibit_o
);
    import sorm_pkg::*;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Routing nibble hits a terminal (terminal index 0..2)
    function automatic logic route_hit(input logic [3:0] field,
                                       input int term);
        logic hit;
        hit = (field != ROUTE_OFF) && (field == 4'(term + 1));
        return hit;
    endfunction : route_hit

    // Bus write of a 16-bit word with byte enables
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0] sel);
        logic [15:0] res;
        res = old;
        if (sel[0])
        begin
            res[7:0] = dat[7:0];
        end
        if (sel[1])
        begin
            res[15:8] = dat[15:8];
        end
        return res;
    endfunction : merge16

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    logic [15:0] route_one_reg;
    logic [15:0] route_two_reg;
    logic [15:0] route_three_reg;
    logic [15:0] polarity_reg;
    logic [3:0] mode_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic bus_req;
    logic bus_wr;
    logic [15:0] status_word;

    // Request seen, answer one cycle later
    assign bus_req = wb_cyc_i && wb_stb_i;
    // Write lands on the edge where the master sees ack
    assign bus_wr = bus_req && wb_we_i && ack_reg;

    // ---------------------------------------------------------------
    // Wishbone slave
    // ---------------------------------------------------------------
    // Ack pulses one cycle, then drops so a held strobe is acked every other cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= bus_req && !ack_reg;
        end
    end

    // Read mux; unmapped addresses read zero and ignore writes
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        case (wb_adr_i)
            ADDR_ROUTE_ONE: rdata_next[15:0] = route_one_reg;
            ADDR_ROUTE_TWO: rdata_next[15:0] = route_two_reg;
            ADDR_ROUTE_THREE: rdata_next[15:0] = route_three_reg;
            ADDR_POLARITY: rdata_next[15:0] = polarity_reg;
            ADDR_MODE: rdata_next[3:0] = mode_reg;
            ADDR_STATUS: rdata_next[15:0] = status_word;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // Read data captured with the ack so it comes from a flip-flop
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else if (bus_req && !ack_reg)
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // Configuration registers; live values feed logic on the next edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            route_one_reg <= RST_ROUTE_ONE;
            route_two_reg <= RST_ROUTE_TWO;
            route_three_reg <= RST_ROUTE_THREE;
            polarity_reg <= RST_POLARITY;
            mode_reg <= RST_MODE;
        end
        else if (bus_wr)
        begin
            case (wb_adr_i)
                ADDR_ROUTE_ONE:
                    route_one_reg <= merge16(route_one_reg, wb_dat_i,
                                             wb_sel_i);
                ADDR_ROUTE_TWO:
                    route_two_reg <= merge16(route_two_reg, wb_dat_i,
                                             wb_sel_i);
                ADDR_ROUTE_THREE:
                    route_three_reg <= merge16(route_three_reg, wb_dat_i,
                                               wb_sel_i);
                ADDR_POLARITY:
                    polarity_reg <= merge16(polarity_reg, wb_dat_i,
                                            wb_sel_i);
                ADDR_MODE:
                    if (wb_sel_i[0])
                    begin
                        mode_reg <= wb_dat_i[3:0];
                    end
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Contact input synchronisers
    // ---------------------------------------------------------------
    // Pins are asynchronous; second stage is the only reader of the first
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_meta_reg <= 4'hF;
            pin_sync_reg <= 4'hF;
        end
        else
        begin
            pin_meta_reg <= {speed_select_b_n_i, speed_select_a_n_i,
                             speed_select_direction_n_i,
                             proportional_control_input_n_i};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    logic pcon_on;
    logic dir_on;
    logic speed_select_a_on;
    logic speed_select_b_on;
    assign pcon_on = !pin_sync_reg[0];
    assign dir_on = !pin_sync_reg[1];
    assign speed_select_a_on = !pin_sync_reg[2];
    assign speed_select_b_on = !pin_sync_reg[3];

    // ---------------------------------------------------------------
    // Control mode decode
    // ---------------------------------------------------------------
    sorm_loop_t loop_next;
    logic clamp_next;
    logic inhibit_next;
    logic ab_off;
    assign ab_off = !speed_select_a_on && !speed_select_b_on;

    // Modes 7..9: input off keeps the first loop, on picks the second; 4..6 leave contact when A and B are off
    always_comb
    begin
        loop_next = LOOP_SPEED;
        clamp_next = 1'b0;
        inhibit_next = 1'b0;
        case (mode_reg)
            MD_SPEED: loop_next = LOOP_SPEED;
            MD_POS: loop_next = LOOP_POSITION;
            MD_TORQUE: loop_next = LOOP_TORQUE;
            MD_CONTACT: loop_next = LOOP_CONTACT;
            MD_CONT_SPEED:
                loop_next = ab_off ? LOOP_SPEED : LOOP_CONTACT;
            MD_CONT_POS:
                loop_next = ab_off ? LOOP_POSITION : LOOP_CONTACT;
            MD_CONT_TORQUE:
                loop_next = ab_off ? LOOP_TORQUE : LOOP_CONTACT;
            MD_POS_SPEED:
                loop_next = pcon_on ? LOOP_SPEED : LOOP_POSITION;
            MD_POS_TORQUE:
                loop_next = pcon_on ? LOOP_TORQUE : LOOP_POSITION;
            MD_TORQUE_SPEED:
                loop_next = pcon_on ? LOOP_SPEED : LOOP_TORQUE;
            MD_CLAMP:
            begin
                loop_next = LOOP_SPEED;
                clamp_next = pcon_on;
            end
            MD_INHIBIT:
            begin
                loop_next = LOOP_POSITION;
                inhibit_next = pcon_on;
            end
            // Unlisted digits fall back to analog speed, the safe default
            default: loop_next = LOOP_SPEED;
        endcase
    end

    // Preset speed: A only -> 1, A and B -> 2, B only -> 3, none -> stop
    logic [1:0] speed_sel_next;
    always_comb
    begin
        speed_sel_next = 2'd0;
        if (loop_next == LOOP_CONTACT)
        begin
            case ({speed_select_b_on, speed_select_a_on})
                2'b01: speed_sel_next = 2'd1;
                2'b11: speed_sel_next = 2'd2;
                2'b10: speed_sel_next = 2'd3;
                default: speed_sel_next = 2'd0;
            endcase
        end
    end

    // Mode outputs registered
    sorm_loop_t loop_reg;
    logic [1:0] speed_sel_reg;
    logic reverse_reg;
    logic clamp_reg;
    logic inhibit_reg;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            loop_reg <= LOOP_SPEED;
            speed_sel_reg <= 2'd0;
            reverse_reg <= 1'b0;
            clamp_reg <= 1'b0;
            inhibit_reg <= 1'b0;
        end
        else
        begin
            loop_reg <= loop_next;
            speed_sel_reg <= speed_sel_next;
            reverse_reg <= (loop_next == LOOP_CONTACT) && dir_on;
            clamp_reg <= clamp_next;
            inhibit_reg <= inhibit_next;
        end
    end

    assign active_loop_o = loop_reg;
    assign preset_speed_o = speed_sel_reg;
    assign speed_reverse_o = reverse_reg;
    assign zero_clamp_o = clamp_reg;
    assign pulse_inhibit_o = inhibit_reg;

    // ---------------------------------------------------------------
    // Output routing
    // ---------------------------------------------------------------
    logic [NUM_FUNC-1:0] func_raw;
    logic [NUM_FUNC-1:0] func_valid;
    logic [NIBBLE_W-1:0] route_field [NUM_FUNC];
    logic [NUM_TERM-1:0] term_or;
    logic [NUM_TERM-1:0] term_next;
    logic [NUM_TERM-1:0] term_reg;

    assign func_raw = {near_position_i, warning_i, brake_interlock_i,
                       speed_limit_detected_i, torque_limit_detected_i,
                       servo_ready_i, rotation_detected_i,
                       speed_coincidence_i, positioning_completed_i};

    // Positioning only in position loop, coincidence only in speed loops
    always_comb
    begin
        func_valid = func_raw;
        func_valid[0] = func_raw[0] && (loop_reg == LOOP_POSITION);
        func_valid[1] = func_raw[1] && (loop_reg == LOOP_SPEED ||
                                        loop_reg == LOOP_CONTACT);
    end

    // Field order: word one, word two, then word three low nibble
    assign route_field[0] = route_one_reg[3:0];
    assign route_field[1] = route_one_reg[7:4];
    assign route_field[2] = route_one_reg[11:8];
    assign route_field[3] = route_one_reg[15:12];
    assign route_field[4] = route_two_reg[3:0];
    assign route_field[5] = route_two_reg[7:4];
    assign route_field[6] = route_two_reg[11:8];
    assign route_field[7] = route_two_reg[15:12];
    assign route_field[8] = route_three_reg[3:0];

    // OR of routed functions, then the terminal's inversion
    for (genvar t = 0; t < NUM_TERM; t++)
    begin : g_term
        logic [NUM_FUNC-1:0] hits;
        for (genvar f = 0; f < NUM_FUNC; f++)
        begin : g_func
            assign hits[f] = func_valid[f] && route_hit(route_field[f], t);
        end
        assign term_or[t] = |hits;
        assign term_next[t] = term_or[t] ^
            (polarity_reg[t*NIBBLE_W +: NIBBLE_W] == POL_INVERT);
    end

    // Terminal outputs from flip-flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            term_reg <= '0;
        end
        else
        begin
            term_reg <= term_next;
        end
    end

    assign output_terminal_one_o = term_reg[0];
    assign output_terminal_two_o = term_reg[1];
    assign output_terminal_three_o = term_reg[2];

    // Status word for software
    always_comb
    begin
        status_word = 16'h0000;
        status_word[ST_TERM_LSB +: NUM_TERM] = term_reg;
        status_word[ST_MODE_LSB +: 2] = loop_reg;
        status_word[ST_SPEED_LSB +: 2] = speed_sel_reg;
        status_word[ST_REVERSE] = reverse_reg;
        status_word[ST_CLAMP] = clamp_reg;
        status_word[ST_INHIBIT] = inhibit_reg;
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req_fresh;
        bus_req && !ack_reg;
    endsequence
    sequence s_ack_pulse;
        ack_reg ##1 !ack_reg;
    endsequence

    property p_ack_timing;
        s_req_fresh |=> s_ack_pulse;
    endproperty
    a_ack_timing: assert property (p_ack_timing)
        else $error("ack not a one-cycle pulse after request");

    property p_reset_route;
        $fell(rst_i) |-> route_one_reg == 16'h3211
            && route_two_reg == 16'h0000;
    endproperty
    a_reset_route: assert property (@(posedge clk_i) p_reset_route)
        else $error("routing words wrong after reset");

    property p_reset_aux;
        $fell(rst_i) |-> route_three_reg == 16'h0000
            && polarity_reg == 16'h0000 && mode_reg == 4'h0;
    endproperty
    a_reset_aux: assert property (@(posedge clk_i) p_reset_aux)
        else $error("aux words wrong after reset");

    property p_term_one;
        ##1 output_terminal_one_o == ($past(term_or[0])
            ^ ($past(polarity_reg[3:0]) == 4'h1));
    endproperty
    a_term_one: assert property (p_term_one)
        else $error("terminal one value wrong");

    property p_ready_default;
        (route_one_reg == 16'h3211 && polarity_reg == 16'h0000
            && servo_ready_i) |=> output_terminal_three_o;
    endproperty
    a_ready_default: assert property (p_ready_default)
        else $error("ready not on terminal three");

    property p_disabled;
        (route_two_reg == 16'h0000 && route_three_reg == 16'h0000
            && route_one_reg == 16'h0000 && polarity_reg[11:0] == 12'h000)
            |=> term_reg == 3'b000;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled functions drive a terminal");

    property p_positioning_completed_mask;
        (loop_reg != LOOP_POSITION && route_one_reg == 16'h0001
            && route_two_reg == 16'h0000 && route_three_reg == 16'h0000
            && polarity_reg[3:0] == 4'h0) |=> !output_terminal_one_o;
    endproperty
    a_positioning_completed_mask: assert property (p_positioning_completed_mask)
        else $error("positioning output outside position loop");

    property p_mode_four;
        (mode_reg == 4'h4 && !speed_select_a_on && !speed_select_b_on)
            |=> active_loop_o == LOOP_SPEED;
    endproperty
    a_mode_four: assert property (p_mode_four)
        else $error("mode 4 did not leave contact control");

    property p_mode_seven;
        (mode_reg == 4'h7) |=> active_loop_o ==
            ($past(pcon_on) ? LOOP_SPEED : LOOP_POSITION);
    endproperty
    a_mode_seven: assert property (p_mode_seven)
        else $error("mode 7 switch wrong");

    property p_mode_eight;
        (mode_reg == 4'h8 && pcon_on) |=> active_loop_o == LOOP_TORQUE;
    endproperty
    a_mode_eight: assert property (p_mode_eight)
        else $error("mode 8 switch wrong");

    property p_clamp;
        (mode_reg == 4'hA) |=> zero_clamp_o == $past(pcon_on);
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("zero clamp not following input");

endmodule : sorm_top

`default_nettype wire

// file: tb/sorm_host_model.sv
// Host controller side: drives the contact pins of the routing block.
// Assumes contacts change only at clock edges; closed contact reads low.
`timescale 1ns/1ps
`default_nettype none

module sorm_host_model (
    input wire logic clk_i,
    input wire logic [3:0] on_i,
    output var logic [3:0] pin_n_o = 4'hF
);
    // Contacts {prop, dir, a, b}; open contacts are driven high by inverting on_i
    always @(posedge clk_i)
    begin
        pin_n_o <= ~on_i;
    end
endmodule : sorm_host_model

`default_nettype wire

// file: tb/sorm_top_tb.sv
// Bench for sorm_top: register access, routing, polarity and mode decode.
// Assumes the host model drives the contact pins; 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module sorm_top_tb;
    import sorm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic [8:0] fn = 9'h000;
    logic [3:0] on = 4'h0;
    logic [3:0] pin_n;
    logic [2:0] term;
    logic [1:0] act_loop;
    logic [1:0] spd;
    logic [2:0] flags;
    int err_count = 0;
    int total_checks = 0;
    // Mode, contacts {prop,dir,a,b}, expected status bits under 0x1F30
    localparam logic [23:0] MT [22] = '{
        24'h00_0000, 24'h10_0010, 24'h20_0020, 24'h30_0030,
        24'h40_0000, 24'h42_0130, 24'h50_0010, 24'h60_0020,
        24'h70_0010, 24'h78_0000, 24'h80_0010, 24'h88_0020,
        24'h90_0020, 24'h98_0000, 24'hA8_0800, 24'hA0_0000,
        24'hB8_1010, 24'hB0_0010, 24'h33_0230, 24'h31_0330,
        24'h34_0430, 24'hC8_0000};

    always #50 clk_i = ~clk_i;

    sorm_top sorm_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .positioning_completed_i(fn[0]), .speed_coincidence_i(fn[1]),
        .rotation_detected_i(fn[2]), .servo_ready_i(fn[3]),
        .torque_limit_detected_i(fn[4]), .speed_limit_detected_i(fn[5]),
        .brake_interlock_i(fn[6]), .warning_i(fn[7]),
        .near_position_i(fn[8]),
        .proportional_control_input_n_i(pin_n[3]),
        .speed_select_direction_n_i(pin_n[2]),
        .speed_select_a_n_i(pin_n[1]), .speed_select_b_n_i(pin_n[0]),
        .output_terminal_one_o(term[0]), .output_terminal_two_o(term[1]),
        .output_terminal_three_o(term[2]), .active_loop_o(act_loop),
        .preset_speed_o(spd), .speed_reverse_o(flags[0]),
        .zero_clamp_o(flags[1]), .pulse_inhibit_o(flags[2]));

    sorm_host_model sorm_host_model_inst (.clk_i(clk_i), .on_i(on),
        .pin_n_o(pin_n));

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Single cycle; held until ack is sampled, bounded so a hang shows
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [15:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(ack), 32'h0000_0001);
        q = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 16'h0000, q);
        chk(q, exp);
    endtask : rd

    // Terminals settle one edge after the functions; extra slack is harmless
    task automatic tchk(input logic [8:0] f, input logic [2:0] exp);
        fn <= f;
        repeat (3) @(posedge clk_i);
        chk(32'(term), 32'(exp));
    endtask : tchk

    task automatic give_verdict;
        $display("Checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        rd(ADDR_ROUTE_ONE, 32'h0000_3211);
        rd(ADDR_ROUTE_TWO, 32'h0000_0000);
        rd(ADDR_ROUTE_THREE, 32'h0000_0000);
        rd(ADDR_POLARITY, 32'h0000_0000);
        rd(ADDR_MODE, 32'h0000_0000);
        rd(8'h18, 32'h0000_0000); // Unmapped place reads zero
    endtask : t_reset

    task automatic t_route;
        tchk(9'h00D, 3'b110);
        tchk(9'h002, 3'b001);
        wr(ADDR_ROUTE_ONE, 16'h0000);
        wr(ADDR_ROUTE_TWO, 16'h0211);
        wr(ADDR_ROUTE_THREE, 16'h0003);
        tchk(9'h010, 3'b001);
        tchk(9'h030, 3'b001);
        tchk(9'h08E, 3'b000);
        tchk(9'h040, 3'b010);
        tchk(9'h100, 3'b100);
    endtask : t_route

    // Digit 3 set too: it must change nothing
    task automatic t_polarity;
        wr(ADDR_POLARITY, 16'h1011);
        tchk(9'h030, 3'b010);
        tchk(9'h000, 3'b011);
        wr(ADDR_POLARITY, 16'h0000);
        tchk(9'h000, 3'b000);
    endtask : t_polarity

    task automatic t_modes;
        logic [31:0] q;
        foreach (MT[i])
        begin
            on <= MT[i][19:16];
            wr(ADDR_MODE, {12'h000, MT[i][23:20]});
            repeat (6) @(posedge clk_i);
            bus(1'b0, ADDR_STATUS, 16'h0000, q);
            chk(q & 32'h0000_1F30, {16'h0000, MT[i][15:0]});
            // Mode ports laid out like the status word
            chk({19'h0_0000, flags, spd, 2'b00, act_loop, 4'h0},
                {16'h0000, MT[i][15:0]});
        end
        wr(ADDR_ROUTE_ONE, 16'h3211);
        wr(ADDR_MODE, {12'h000, MD_POS});
        tchk(9'h003, 3'b001);
        tchk(9'h002, 3'b000);
        // Positioning routed alone stays quiet once back in speed loop
        wr(ADDR_ROUTE_ONE, 16'h0001);
        wr(ADDR_MODE, {12'h000, MD_SPEED});
        tchk(9'h001, 3'b000);
    endtask : t_modes

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_route();
        t_polarity();
        t_modes();
        give_verdict();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        give_verdict();
    end
endmodule : sorm_top_tb

`default_nettype wire
